// ---- include/pll_prog_params.svh ----
/*
 * constants of the counter programming port: widths, enhancement bit
 * positions and reset values.
 * assumes nothing; included by the package and the design file.
 */
`ifndef PLL_PROG_PARAMS_SVH
`define PLL_PROG_PARAMS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define PRIM_WIDTH      20
`define ENH_WIDTH       8
`define BUS_WIDTH       8
`define MAIN_WIDTH      9
`define REF_WIDTH       6
`define SWALLOW_WIDTH   4

// ****************************************************************
// enhancement register bit positions
// ****************************************************************
`define ENH_FP_OFF      0
`define ENH_FC_OFF      1
`define ENH_DOUT_EN     2

// ****************************************************************
// reset values
// ****************************************************************
`define PRIM_RESET      20'h00000
`define SEC_RESET       20'h00000
`define ENH_RESET       8'h00

`endif

// ---- include/pll_prog_pkg.sv ----
/*
 * types of the counter programming port: interface modes, counter
 * word layout, synchronised pin bundle and the module state.
 * assumes pll_prog_params.svh on the include path.
 */
`include "pll_prog_params.svh"

package pll_prog_pkg;

  // ****************************************************************
  // modes and carriers
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_DIRECT,
    MODE_SERIAL,
    MODE_PARALLEL
  } mode_e;

  // one counter word, msb first as it is shifted in
  typedef struct packed {
    logic [`MAIN_WIDTH-1:0]    mainCnt;
    logic                      preEnN;
    logic [`REF_WIDTH-1:0]     refCnt;
    logic [`SWALLOW_WIDTH-1:0] swallowCnt;
  } cnt_s;

  // every pin that enters from the host or the divider chain
  typedef struct packed {
    logic                      sdata;
    logic                      sclk;
    logic                      serLoad;
    logic                      hopStrobe;
    logic                      enhStrobe;
    logic                      mainLoStrobe;
    logic                      mainHiStrobe;
    logic                      swallowStrobe;
    logic                      serMode;
    logic                      baseMode;
    logic                      serRegSelect;
    logic                      parRegSelect;
    logic                      enhModeN;
    logic [`BUS_WIDTH-1:0]     dataBus;
    logic [3:0]                refPins;
    logic [`SWALLOW_WIDTH-1:0] swallowPins;
    logic                      mainDiv;
    logic                      refDiv;
  } pins_s;

  typedef struct packed {
    pins_s                     sync1;
    pins_s                     sync2;
    pins_s                     prev;
    cnt_s                      primary;
    cnt_s                      secondary;
    logic [`ENH_WIDTH-1:0]     enh_mode_n;
    cnt_s                      counters;
    logic [`ENH_WIDTH-1:0]     enhApplied;
    logic                      prescalerBypass;
    logic                      fpMon;
    logic                      fcMon;
    logic                      dataOut;
    mode_e                     mode;
  } state_s;

endpackage

// ---- rtl/pll_counter_program_port.sv ----
/*
 * programming front end of an integer-n synthesizer: serial and parallel
 * loading of the primary, secondary and enhancement words, a direct word from the pins,
 * selection of the word that drives the counters, monitor gating.
 * assumes every pin input is asynchronous to ref_clk and is held
 * stable for at least four ref_clk periods around each strobe edge.
 */
`timescale 1ns/1ns
`include "pll_prog_params.svh"

module pll_counter_program_port (
  input  wire logic                               ref_clk,
  input  wire logic                               nrst,
  input  wire logic                               sdata,
  input  wire logic                               sclk,
  input  wire logic                               serLoad,
  input  wire logic                               hopStrobe,
  input  wire logic                               enhStrobe,
  input  wire logic                               mainLoStrobe,
  input  wire logic                               mainHiStrobe,
  input  wire logic                               swallowStrobe,
  input  wire logic                               serMode,
  input  wire logic                               baseMode,
  input  wire logic                               serRegSelect,
  input  wire logic                               parRegSelect,
  input  wire logic                               enhModeN,
  input  wire logic [`BUS_WIDTH-1:0]              dataBus,
  input  wire logic [3:0]                         refPins,
  input  wire logic [`SWALLOW_WIDTH-1:0]          swallowPins,
  input  wire logic                               mainDiv,
  input  wire logic                               refDiv,
  output logic      [`MAIN_WIDTH-1:0]             mainCount,
  output logic      [`REF_WIDTH-1:0]              refCount,
  output logic      [`SWALLOW_WIDTH-1:0]          swallowCount,
  output logic                                    prescalerEnN,
  output logic                                    prescalerBypass,
  output logic      [`ENH_WIDTH-1:0]              enhBits,
  output pll_prog_pkg::mode_e                     activeMode,
  output logic                                    fpMon,
  output logic                                    fcMon,
  output logic                                    dataOut
);
  import pll_prog_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  state_s state_reg;
  state_s state_next;
  pins_s  pinsRaw;
  pins_s  rise;
  cnt_s   directWord;
  cnt_s   chosen;
  mode_e  modeNow;
  logic [`ENH_WIDTH-1:0] enhNow;

  assign pinsRaw = '{
    sdata:         sdata,
    sclk:          sclk,
    serLoad:       serLoad,
    hopStrobe:     hopStrobe,
    enhStrobe:     enhStrobe,
    mainLoStrobe:  mainLoStrobe,
    mainHiStrobe:  mainHiStrobe,
    swallowStrobe: swallowStrobe,
    serMode:       serMode,
    baseMode:      baseMode,
    serRegSelect:  serRegSelect,
    parRegSelect:  parRegSelect,
    enhModeN:      enhModeN,
    dataBus:       dataBus,
    refPins:       refPins,
    swallowPins:   swallowPins,
    mainDiv:       mainDiv,
    refDiv:        refDiv
  };

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_next       = state_reg;
    state_next.sync1 = pinsRaw;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;

    // rising edges seen on the second sync stage only
    rise = state_reg.sync2 & ~state_reg.prev;

    if (state_reg.sync2.baseMode) begin
      modeNow = MODE_DIRECT;
    end else if (state_reg.sync2.serMode) begin
      modeNow = MODE_SERIAL;
    end else begin
      modeNow = MODE_PARALLEL;
    end
    state_next.mode = modeNow;

    unique case (modeNow)
      MODE_SERIAL: begin
        if (rise.sclk && !state_reg.sync2.serLoad) begin
          if (state_reg.sync2.enhStrobe) begin
            state_next.enh_mode_n = {state_reg.enh_mode_n[`ENH_WIDTH-2:0],
                              state_reg.sync2.sdata};
          end else begin
            state_next.primary = cnt_s'({
              state_reg.primary[`PRIM_WIDTH-2:0],
              state_reg.sync2.sdata});
          end
        end
        if (rise.serLoad || rise.hopStrobe) begin
          state_next.secondary = state_reg.primary;
        end
      end
      MODE_PARALLEL: begin
        if (rise.enhStrobe) begin
          state_next.enh_mode_n = state_reg.sync2.dataBus;
        end
        if (rise.mainLoStrobe) begin
          state_next.primary.preEnN       = state_reg.sync2.dataBus[7];
          state_next.primary.mainCnt[6:0] =
            state_reg.sync2.dataBus[6:0];
        end
        if (rise.mainHiStrobe) begin
          state_next.primary.refCnt[5:4]  = state_reg.sync2.dataBus[3:2];
          state_next.primary.mainCnt[8:7] = state_reg.sync2.dataBus[1:0];
        end
        if (rise.swallowStrobe) begin
          state_next.primary.refCnt[3:0] = state_reg.sync2.dataBus[7:4];
          state_next.primary.swallowCnt  = state_reg.sync2.dataBus[3:0];
        end
        if (rise.hopStrobe) begin
          state_next.secondary = state_reg.primary;
        end
      end
      MODE_DIRECT: begin
      end
    endcase

    // direct word straight from the pins
    directWord            = '0;
    directWord.mainCnt    = {2'h0, state_reg.sync2.dataBus[6:0]};
    directWord.preEnN     = state_reg.sync2.dataBus[7];
    directWord.refCnt     = {2'h0, state_reg.sync2.refPins};
    directWord.swallowCnt = state_reg.sync2.swallowPins;

    unique case (modeNow)
      MODE_DIRECT:   chosen = directWord;
      MODE_SERIAL:   chosen = state_reg.sync2.serRegSelect
                              ? state_reg.primary
                              : state_reg.secondary;
      MODE_PARALLEL: chosen = state_reg.sync2.parRegSelect
                              ? state_reg.primary
                              : state_reg.secondary;
    endcase
    state_next.counters        = chosen;
    state_next.prescalerBypass = chosen.preEnN;

    // enhancement bits only act in the bus modes with the pin low
    if (state_reg.sync2.enhModeN || modeNow == MODE_DIRECT) begin
      enhNow = '0;
    end else begin
      enhNow = state_reg.enh_mode_n;
    end
    state_next.enhApplied = enhNow;

    state_next.fpMon   = state_reg.sync2.mainDiv
                         & ~enhNow[`ENH_FP_OFF];
    state_next.fcMon   = state_reg.sync2.refDiv & ~enhNow[`ENH_FC_OFF];
    state_next.dataOut = state_reg.sync2.mainDiv & enhNow[`ENH_DOUT_EN];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg           <= '0;
      state_reg.primary   <= cnt_s'(`PRIM_RESET);
      state_reg.secondary <= cnt_s'(`SEC_RESET);
      state_reg.enh_mode_n       <= `ENH_RESET;
      state_reg.mode      <= MODE_DIRECT;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign mainCount       = state_reg.counters.mainCnt;
  assign refCount        = state_reg.counters.refCnt;
  assign swallowCount    = state_reg.counters.swallowCnt;
  assign prescalerEnN    = state_reg.counters.preEnN;
  assign prescalerBypass = state_reg.prescalerBypass;
  assign enhBits         = state_reg.enhApplied;
  assign activeMode      = state_reg.mode;
  assign fpMon           = state_reg.fpMon;
  assign fcMon           = state_reg.fcMon;
  assign dataOut         = state_reg.dataOut;

endmodule // pll_counter_program_port

// ---- sim/pll_prog_properties.sv ----
/*
 * checker of the counter programming port, bound to its top module.
 * assumes pll_prog_pkg is compiled before this file.
 */
`timescale 1ns/1ns
`include "pll_prog_params.svh"

module pll_prog_properties (
  input wire logic                       ref_clk,
  input wire logic                       nrst,
  input wire logic                       baseMode,
  input wire logic                       serMode,
  input wire logic                       enhModeN,
  input wire logic [`BUS_WIDTH-1:0]      dataBus,
  input wire logic [3:0]                 refPins,
  input wire logic [`SWALLOW_WIDTH-1:0]  swallowPins,
  input wire logic                       mainDiv,
  input wire logic [`MAIN_WIDTH-1:0]     mainCount,
  input wire logic [`REF_WIDTH-1:0]      refCount,
  input wire logic [`SWALLOW_WIDTH-1:0]  swallowCount,
  input wire logic                       prescalerEnN,
  input wire logic                       prescalerBypass,
  input wire logic [`ENH_WIDTH-1:0]      enhBits,
  input wire pll_prog_pkg::mode_e        activeMode,
  input wire logic                       fpMon,
  input wire logic                       dataOut
);
  import pll_prog_pkg::*;
  // ******
  // properties
  // ******
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence pinsHeld_s;
    (baseMode && $stable(dataBus) && $stable(refPins)
      && $stable(swallowPins)) [*7];
  endsequence
  direct_mode_a: assert property (baseMode [*6] |-> activeMode == MODE_DIRECT)
    else $error("direct mode not taken");
  serial_mode_a: assert property ((!baseMode && serMode) [*6] |-> activeMode == MODE_SERIAL)
    else $error("serial mode not taken");
  par_mode_a: assert property ((!baseMode && !serMode) [*6] |-> activeMode == MODE_PARALLEL)
    else $error("parallel mode not taken");
  direct_word_a: assert property (pinsHeld_s |->
    {mainCount, prescalerEnN, refCount, swallowCount} ==
    {2'h0, dataBus[6:0], dataBus[7], 2'h0, refPins, swallowPins})
    else $error("direct word differs from pins");
  bypass_follow_a: assert property ($stable(prescalerEnN) [*3] |-> prescalerBypass == prescalerEnN)
    else $error("bypass differs from prescaler enable");
  enh_off_a: assert property ((enhModeN || baseMode) [*6] |-> enhBits == 8'h00)
    else $error("enhancement bits active while off");
  fp_silent_a: assert property (enhBits[0] [*3] |-> !fpMon)
    else $error("monitor not silenced");
  fp_follow_a: assert property ((!enhBits[0] && $stable(mainDiv)) [*6] |-> fpMon == mainDiv)
    else $error("monitor does not follow divider");
  dout_idle_a: assert property (!enhBits[2] [*3] |-> !dataOut)
    else $error("data out active while disabled");
endmodule // pll_prog_properties

bind pll_counter_program_port pll_prog_properties i_props (.*);

// ---- sim/pll_host_model.sv ----
/*
 * host controller model driving every programming pin of the port.
 * assumes ref_clk from the bench; pins idle at their pull-down level.
 */
`timescale 1ns/1ns

module pll_host_model (
  input  wire logic             ref_clk,
  output pll_prog_pkg::pins_s   p
);
  import pll_prog_pkg::*;
  logic [3:0] divCnt = 4'h0;
  initial p = '0;
  // divider levels, slow enough for the monitor to settle
  always @(posedge ref_clk) begin
    divCnt <= divCnt + 4'h1;
    if (divCnt == 4'hf) p.mainDiv <= ~p.mainDiv;
    if (divCnt[2:0] == 3'h4) p.refDiv <= ~p.refDiv;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // k: 0 hop, 1 enh, 2 main low, 3 main high, 4 swallow, 5 load
  task automatic pulse(input int k, input logic [7:0] d);
    p.dataBus <= d;
    tick(4);
    case (k)
      0: p.hopStrobe <= 1'b1;
      1: p.enhStrobe <= 1'b1;
      2: p.mainLoStrobe <= 1'b1;
      3: p.mainHiStrobe <= 1'b1;
      4: p.swallowStrobe <= 1'b1;
      default: p.serLoad <= 1'b1;
    endcase
    tick(4);
    {p.hopStrobe, p.enhStrobe, p.mainLoStrobe, p.mainHiStrobe,
      p.swallowStrobe, p.serLoad} <= 6'h00;
    tick(4);
    p.dataBus <= 8'h00;
    tick(4);
  endtask
  task automatic ser(input logic [19:0] w, input int n, input logic e);
    p.enhStrobe <= e;
    for (int i = n - 1; i >= 0; i--) begin
      p.sdata <= w[i];
      tick(4);
      p.sclk <= 1'b1;
      tick(4);
      p.sclk <= 1'b0;
    end
    p.sdata <= 1'b0;
    p.enhStrobe <= 1'b0;
    tick(8);
  endtask
endmodule // pll_host_model

// ---- sim/pll_counter_program_port_test.sv ----
/*
 * self-checking bench of the counter programming port.
 * assumes the design, package, checker and host model are compiled.
 */
`timescale 1ns/1ns

module pll_counter_program_port_test;
  import pll_prog_pkg::*;
  localparam logic [19:0] W1 = 20'h5a3c7;
  localparam logic [19:0] W2 = 20'hc18e2;
  localparam logic [19:0] PW = {9'h11b, 1'b1, 6'h36, 4'hc};
  logic       ref_clk     = 1'b0;
  logic       nrst        = 1'b0;
  int         fails       = 0;
  int         checks_done = 0;
  pins_s      p;
  cnt_s       word;
  logic [7:0] enh_mode_n;
  logic       bypass;
  mode_e      mode;
  logic       fp;
  logic       fc;
  logic       dout;
  pll_host_model i_host (.ref_clk(ref_clk), .p(p));
  pll_counter_program_port i_dut (.ref_clk(ref_clk), .nrst(nrst),
    .sdata(p.sdata), .sclk(p.sclk), .serLoad(p.serLoad),
    .hopStrobe(p.hopStrobe), .enhStrobe(p.enhStrobe),
    .mainLoStrobe(p.mainLoStrobe), .mainHiStrobe(p.mainHiStrobe),
    .swallowStrobe(p.swallowStrobe), .serMode(p.serMode),
    .baseMode(p.baseMode), .serRegSelect(p.serRegSelect),
    .parRegSelect(p.parRegSelect), .enhModeN(p.enhModeN),
    .dataBus(p.dataBus), .refPins(p.refPins),
    .swallowPins(p.swallowPins), .mainDiv(p.mainDiv), .refDiv(p.refDiv),
    .mainCount(word.mainCnt), .refCount(word.refCnt),
    .swallowCount(word.swallowCnt), .prescalerEnN(word.preEnN),
    .prescalerBypass(bypass), .enhBits(enh_mode_n), .activeMode(mode),
    .fpMon(fp), .fcMon(fc), .dataOut(dout));
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input string s, input logic [19:0] e, input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    i_host.tick(4);
    i_host.p.serMode <= 1'b1;
    i_host.p.serRegSelect <= 1'b1;
    i_host.ser(W1, 20, 1'b0);
    chk("serial primary", W1, word);
    chk("serial mode", {18'h0, MODE_SERIAL}, {18'h0, mode});
    i_host.p.serRegSelect <= 1'b0;
    i_host.tick(8);
    chk("serial secondary", 20'h0, word);
    i_host.pulse(5, 8'h00);
    chk("load copy", W1, word);
    i_host.ser(W2, 20, 1'b0);
    i_host.pulse(0, 8'h00);
    chk("serial hop", W2, word);
    i_host.ser(20'h05, 8, 1'b1);
    chk("serial enh", 20'h05, {12'h0, enh_mode_n});
    chk("fp silenced", 20'h0, {19'h0, fp});
    // data out enabled: it must follow the divider within a few toggles
    for (int i = 0; i < 40 && !dout; i++) i_host.tick(1);
    chk("dout activity", 20'h1, {19'h0, dout});
    i_host.p.enhModeN <= 1'b1;
    i_host.tick(8);
    chk("enh masked", 20'h0, {12'h0, enh_mode_n});
    // enhancement masked: the reference monitor must still switch
    for (int i = 0; i < 40 && !fc; i++) i_host.tick(1);
    chk("fc activity", 20'h1, {19'h0, fc});
    i_host.p.enhModeN <= 1'b0;
    i_host.p.serMode <= 1'b0;
    i_host.p.parRegSelect <= 1'b1;
    i_host.pulse(2, 8'h9b);
    i_host.pulse(3, 8'h0e);
    i_host.pulse(4, 8'h6c);
    chk("parallel word", PW, word);
    chk("bypass", 20'h1, {19'h0, bypass});
    chk("parallel mode", {18'h0, MODE_PARALLEL}, {18'h0, mode});
    i_host.p.parRegSelect <= 1'b0;
    i_host.tick(8);
    chk("parallel secondary", W2, word);
    i_host.pulse(0, 8'h00);
    chk("parallel hop", PW, word);
    i_host.ser(W1, 20, 1'b0);
    i_host.p.parRegSelect <= 1'b1;
    i_host.tick(8);
    chk("serial refused", PW, word);
    i_host.pulse(1, 8'h81);
    chk("parallel enh", 20'h81, {12'h0, enh_mode_n});
    i_host.p.baseMode <= 1'b1;
    i_host.p.dataBus <= 8'ha3;
    i_host.p.refPins <= 4'h5;
    i_host.p.swallowPins <= 4'h9;
    i_host.tick(8);
    chk("direct word", {9'h023, 1'b1, 6'h05, 4'h9}, word);
    chk("direct enh", 20'h0, {12'h0, enh_mode_n});
    chk("direct mode", {18'h0, MODE_DIRECT}, {18'h0, mode});
    chk("direct dout", 20'h0, {19'h0, dout});
    conclude();
  end
endmodule // pll_counter_program_port_test
